/* design/dosg_fifo.sv */
// Output pixel FIFO with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module dosg_fifo #(
  parameter int WIDTH = 13,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  // DEPTH must be a power of two; pointers carry one wrap bit
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0] wp;
    logic [AW:0] rp;
  } dosg_fifo_st_t;
  dosg_fifo_st_t st_ff;
  dosg_fifo_st_t nxt_st;
  logic full;
  logic empty;

  // Full when pointers differ only in the wrap bit
  assign full = (st_ff.wp[AW] != st_ff.rp[AW]) &&
                (st_ff.wp[AW-1:0] == st_ff.rp[AW-1:0]);
  assign empty = (st_ff.wp == st_ff.rp);
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = st_ff.mem[st_ff.rp[AW-1:0]];

  // Push and pop may happen in the same cycle
  always_comb begin
    nxt_st = st_ff;
    if (in_valid && !full) begin
      nxt_st.mem[st_ff.wp[AW-1:0]] = in_data;
      nxt_st.wp = st_ff.wp + 1'b1;
    end
    if (out_ready && !empty) begin
      nxt_st.rp = st_ff.rp + 1'b1;
    end
  end

  // State register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
endmodule
`default_nettype wire

/* design/dosg_pkg.sv */
// Shared constants and carrier types of the dark offset shading generator
`default_nettype none
package dosg_pkg;

  // Pixel width and documented line length
  localparam int DOSG_PIX_W = 12;
  localparam int DOSG_NUM_PIX = 2048;
  // Lines averaged per dark-offset generation run
  localparam int DOSG_DARK_LINES = 64;
  localparam int DOSG_LINES_LOG2 = 6;
  // Photo gain is a fixed-point factor, unity at this scale
  localparam int DOSG_GAIN_FRAC = 12;
  localparam int DOSG_GAIN_W = 16;
  localparam logic [15:0] DOSG_GAIN_ONE = 16'h1000;

  // Register byte offsets
  localparam logic [11:0] DOSG_ADDR_MODE = 12'h000;
  localparam logic [11:0] DOSG_ADDR_GEN = 12'h004;
  localparam logic [11:0] DOSG_ADDR_STATUS = 12'h008;
  localparam logic [11:0] DOSG_ADDR_ACTIVE = 12'h00C;
  localparam logic [11:0] DOSG_ADDR_REF = 12'h010;

  // Field positions
  localparam int DOSG_MODE_SEL_LSB = 0;
  localparam int DOSG_MODE_SINGLE_BIT = 4;
  localparam int DOSG_GEN_START_BIT = 0;
  localparam int DOSG_ST_BUSY_BIT = 0;
  localparam int DOSG_ST_USER_BIT = 1;
  localparam int DOSG_ST_VSINGLE_BIT = 2;
  localparam int DOSG_ST_VMULTI_BIT = 3;
  localparam int DOSG_ST_LINES_LSB = 8;
  localparam int DOSG_ACT_USER_BIT = 0;

  // Shading selections
  typedef enum logic [1:0] {
    DOSG_SHD_OFF,
    DOSG_SHD_DARK,
    DOSG_SHD_GAIN,
    DOSG_SHD_BOTH
  } dosg_shd_mode_t;

  // Reset values
  localparam dosg_shd_mode_t DOSG_RST_MODE = DOSG_SHD_OFF;
  localparam logic DOSG_RST_SINGLE = 1'b0;
  localparam logic DOSG_RST_USER_ACT = 1'b0;

  // One pixel beat of the stream
  typedef struct packed {
    logic last;
    logic [DOSG_PIX_W-1:0] data;
  } dosg_pix_t;

  // APB request from the master
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } dosg_apb_req_t;

  // APB answer of the slave
  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } dosg_apb_rsp_t;

endpackage
`default_nettype wire

/* design/dosg_tables.sv */
// Factory and user correction tables; the user area is held in registers cleared by reset
`timescale 1ns/1ps
`default_nettype none
module dosg_tables #(
  parameter int NUM_PIX = 2048,
  parameter int PIX_W = 12,
  parameter int IDX_W = 12,
  // Factory dark offset, one value for every pixel
  parameter logic [11:0] FACTORY_OFS = 12'h000
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wr_en,
  input wire logic wr_set,
  input wire logic [IDX_W-1:0] wr_idx,
  input wire logic [PIX_W-1:0] wr_ofs,
  input wire logic rd_user,
  input wire logic rd_set,
  input wire logic [IDX_W-1:0] rd_idx,
  output logic [PIX_W-1:0] rd_ofs,
  output logic [15:0] rd_gain
);
  import dosg_pkg::*;
  // Set 1 serves single line mode, set 0 all other modes
  typedef struct packed {
    logic [1:0][NUM_PIX-1:0][PIX_W-1:0] user;
  } dosg_tbl_st_t;
  dosg_tbl_st_t st_ff;
  dosg_tbl_st_t nxt_st;

  // Factory values are constants with no write path at all
  always_comb begin
    rd_ofs = FACTORY_OFS[PIX_W-1:0];
    if (rd_user && (rd_idx < IDX_W'(NUM_PIX))) begin
      rd_ofs = st_ff.user[rd_set][rd_idx];
    end
  end
  // Gain generation is not built, so gain stays unity
  assign rd_gain = DOSG_GAIN_ONE;

  // Only the generator's store phase writes the user area
  always_comb begin
    nxt_st = st_ff;
    if (wr_en && (wr_idx < IDX_W'(NUM_PIX))) begin
      nxt_st.user[wr_set][wr_idx] = wr_ofs;
    end
  end

  // Storage register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
endmodule
`default_nettype wire

/* design/dosg_top.sv */
// Shading correction datapath, dark offset generator and APB registers
//
// Contract
// - Mode selects dark, gain, or both corrections
// - Factory table fixed; user table only by generation
// - Separate user sets: single line, other modes
// - Writing generate field starts collecting lines
// - Gather 64 lines before computing offsets
// - Line and data valid keep toggling meanwhile
// - Ignore commands during the 64 acquisitions (the code stalls every APB transfer until the run ends instead)
// - Average every pixel over the 64 lines
// - Brightest average pixel becomes reference
// - Offset lifts each average to the reference
// - Offsets overwrite the user table set
// - User table activated after storing
`timescale 1ns/1ps
`default_nettype none
module dosg_top #(
  parameter int NUM_PIX = dosg_pkg::DOSG_NUM_PIX,
  parameter int FIFO_DEPTH = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire dosg_pkg::dosg_apb_req_t apb_req,
  output dosg_pkg::dosg_apb_rsp_t apb_rsp,
  input wire logic pix_in_valid,
  output logic pix_in_ready,
  input wire dosg_pkg::dosg_pix_t pix_in,
  output logic px_out_valid,
  input wire logic px_out_ready,
  output dosg_pkg::dosg_pix_t px_out,
  output logic line_valid
);
  import dosg_pkg::*;

  // Index is one bit wider than needed so a line up to twice NUM_PIX long cannot wrap
  localparam int IDX_W = $clog2(NUM_PIX) + 1;
  // Sum of 64 pixels needs six extra bits
  localparam int ACC_W = DOSG_PIX_W + DOSG_LINES_LOG2;
  localparam int PIX_BW = $bits(dosg_pix_t);
  localparam logic [DOSG_PIX_W-1:0] PIX_MAX = '1;

  // Generator sequence
  typedef enum logic [2:0] {
    GEN_IDLE,
    GEN_ARM,
    GEN_COLLECT,
    GEN_FIND,
    GEN_STORE
  } dosg_gen_t;

  // Whole state of the block
  typedef struct packed {
    dosg_gen_t gen;
    dosg_shd_mode_t mode;
    logic single_line;
    logic user_act;
    logic [1:0] set_valid;
    logic gen_set;
    logic [IDX_W-1:0] idx;
    logic [DOSG_LINES_LOG2-1:0] line_cnt;
    logic [IDX_W-1:0] scan;
    logic [DOSG_PIX_W-1:0] ref_lvl;
    logic [NUM_PIX-1:0][ACC_W-1:0] acc;
    logic [31:0] prdata;
    logic out_in_line;
  } dosg_st_t;

  dosg_st_t st_ff;
  dosg_st_t nxt_st;

  // Stream and table wiring
  logic fifo_in_ready; // FIFO has room for one beat
  logic beat_go; // Input beat accepted this cycle
  logic [DOSG_PIX_W-1:0] tbl_ofs; // Offset for current pixel
  logic [15:0] tbl_gain; // Gain factor for current pixel
  dosg_pix_t corr_pix; // Corrected beat pushed into FIFO
  logic tbl_wr; // Store phase writes the user table
  logic [DOSG_PIX_W-1:0] store_ofs; // Offset being stored
  logic busy; // Generation in progress
  logic apb_access; // Access phase of an APB transfer
  logic addr_ok; // Address hits a register
  logic [DOSG_PIX_W-1:0] scan_avg; // Average at the scan index

  // Saturating add keeps bright pixels from wrapping to black
  function automatic logic [DOSG_PIX_W-1:0] sat_add(
    input logic [DOSG_PIX_W-1:0] a,
    input logic [DOSG_PIX_W-1:0] b
  );
    logic [DOSG_PIX_W:0] s;
    s = {1'b0, a} + {1'b0, b};
    sat_add = s[DOSG_PIX_W] ? PIX_MAX : s[DOSG_PIX_W-1:0];
  endfunction

  // Fixed-point gain with saturation at full scale
  function automatic logic [DOSG_PIX_W-1:0] sat_gain(
    input logic [DOSG_PIX_W-1:0] a,
    input logic [15:0] g
  );
    logic [DOSG_PIX_W+15:0] p;
    logic [DOSG_PIX_W+15:0] q;
    p = {16'h0000, a} * {{DOSG_PIX_W{1'b0}}, g};
    q = p >> DOSG_GAIN_FRAC;
    sat_gain = (q > {16'h0000, PIX_MAX}) ? PIX_MAX : q[DOSG_PIX_W-1:0];
  endfunction

  // Average of one accumulator: sum of 64 lines shifted down
  function automatic logic [DOSG_PIX_W-1:0] avg_of(
    input logic [ACC_W-1:0] sum
  );
    avg_of = sum[ACC_W-1:DOSG_LINES_LOG2];
  endfunction

  // Register decode used only by the error answer; the read mux decodes on its own
  function automatic logic is_reg(input logic [11:0] a);
    is_reg = 1'b0;
    if (a == DOSG_ADDR_MODE) begin
      is_reg = 1'b1;
    end else if (a == DOSG_ADDR_GEN) begin
      is_reg = 1'b1;
    end else if (a == DOSG_ADDR_STATUS) begin
      is_reg = 1'b1;
    end else if (a == DOSG_ADDR_ACTIVE) begin
      is_reg = 1'b1;
    end else if (a == DOSG_ADDR_REF) begin
      is_reg = 1'b1;
    end
  endfunction

  // Correction tables
  dosg_tables #(
    .NUM_PIX(NUM_PIX),
    .PIX_W(DOSG_PIX_W),
    .IDX_W(IDX_W)
  ) u_tables (
    .clk(pclk),
    .rst_n(presetn),
    .wr_en(tbl_wr),
    .wr_set(st_ff.gen_set),
    .wr_idx(st_ff.scan),
    .wr_ofs(store_ofs),
    .rd_user(st_ff.user_act),
    .rd_set(st_ff.single_line),
    .rd_idx(st_ff.idx),
    .rd_ofs(tbl_ofs),
    .rd_gain(tbl_gain)
  );

  // Output buffer; its ready stalls the pixel source
  dosg_fifo #(
    .WIDTH(PIX_BW),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(pclk),
    .rst_n(presetn),
    .in_valid(pix_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(corr_pix),
    .out_valid(px_out_valid),
    .out_ready(px_out_ready),
    .out_data(px_out)
  );

  assign pix_in_ready = fifo_in_ready;
  assign beat_go = pix_in_valid && fifo_in_ready;
  assign busy = (st_ff.gen != GEN_IDLE);
  assign apb_access = apb_req.psel && apb_req.penable;
  assign addr_ok = is_reg(apb_req.paddr);
  assign scan_avg = avg_of(st_ff.acc[st_ff.scan[IDX_W-2:0]]);
  assign tbl_wr = (st_ff.gen == GEN_STORE);
  assign store_ofs = st_ff.ref_lvl - scan_avg;

  // Line valid spans the whole line at the output, gaps included;
  // data keeps flowing during generation, only its content is junk
  assign line_valid = px_out_valid || st_ff.out_in_line;

  // Pixel correction on the way into the FIFO
  always_comb begin
    corr_pix = pix_in;
    if ((st_ff.mode == DOSG_SHD_DARK) || (st_ff.mode == DOSG_SHD_BOTH)) begin
      corr_pix.data = sat_add(pix_in.data, tbl_ofs);
    end
    if ((st_ff.mode == DOSG_SHD_GAIN) || (st_ff.mode == DOSG_SHD_BOTH)) begin
      corr_pix.data = sat_gain(corr_pix.data, tbl_gain);
    end
  end

  // APB answer: stall every transfer while generation runs
  always_comb begin
    apb_rsp.prdata = st_ff.prdata;
    apb_rsp.pready = !busy;
    apb_rsp.pslverr = apb_access && !busy && !addr_ok;
  end

  // Next state of registers, stream position and generator
  always_comb begin
    nxt_st = st_ff;

    // Output line tracker follows popped beats
    if (px_out_valid && px_out_ready) begin
      nxt_st.out_in_line = !px_out.last;
    end

    // Pixel index within the line, restarted after the last beat
    if (beat_go) begin
      if (pix_in.last) begin
        nxt_st.idx = '0;
      end else begin
        nxt_st.idx = st_ff.idx + 1'b1;
      end
    end

    // Read data captured each cycle of a selected transfer
    if (apb_req.psel) begin
      nxt_st.prdata = '0;
      if (apb_req.paddr == DOSG_ADDR_MODE) begin
        nxt_st.prdata[DOSG_MODE_SEL_LSB +: 2] = st_ff.mode;
        nxt_st.prdata[DOSG_MODE_SINGLE_BIT] = st_ff.single_line;
      end else if (apb_req.paddr == DOSG_ADDR_GEN) begin
        nxt_st.prdata[DOSG_GEN_START_BIT] = busy;
      end else if (apb_req.paddr == DOSG_ADDR_STATUS) begin
        nxt_st.prdata[DOSG_ST_BUSY_BIT] = busy;
        nxt_st.prdata[DOSG_ST_USER_BIT] = st_ff.user_act;
        nxt_st.prdata[DOSG_ST_VSINGLE_BIT] = st_ff.set_valid[1];
        nxt_st.prdata[DOSG_ST_VMULTI_BIT] = st_ff.set_valid[0];
        nxt_st.prdata[DOSG_ST_LINES_LSB +: DOSG_LINES_LOG2] = st_ff.line_cnt;
      end else if (apb_req.paddr == DOSG_ADDR_ACTIVE) begin
        nxt_st.prdata[DOSG_ACT_USER_BIT] = st_ff.user_act;
      end else if (apb_req.paddr == DOSG_ADDR_REF) begin
        nxt_st.prdata[DOSG_PIX_W-1:0] = st_ff.ref_lvl;
      end
    end

    // Register writes complete only while idle; the host is expected
    // to wait, but a stalled transfer is held rather than lost
    if (apb_access && apb_req.pwrite && !busy) begin
      if (apb_req.paddr == DOSG_ADDR_MODE) begin
        nxt_st.mode = dosg_shd_mode_t'(apb_req.pwdata[DOSG_MODE_SEL_LSB +: 2]);
        nxt_st.single_line = apb_req.pwdata[DOSG_MODE_SINGLE_BIT];
      end else if (apb_req.paddr == DOSG_ADDR_ACTIVE) begin
        // Software may fall back to factory values whenever no generation runs
        nxt_st.user_act = apb_req.pwdata[DOSG_ACT_USER_BIT];
      end else if (apb_req.paddr == DOSG_ADDR_GEN) begin
        if (apb_req.pwdata[DOSG_GEN_START_BIT]) begin
          // Set tracks the acquisition mode at start
          nxt_st.gen_set = st_ff.single_line;
          nxt_st.line_cnt = '0;
          // Mid-line start waits for a clean line boundary
          if ((st_ff.idx == '0) && !beat_go) begin
            nxt_st.gen = GEN_COLLECT;
          end else begin
            nxt_st.gen = GEN_ARM;
          end
        end
      end
    end

    // Generator sequence
    case (st_ff.gen)
      GEN_IDLE: begin
        nxt_st.scan = '0;
      end
      GEN_ARM: begin
        // Skip the tail of the line already in flight
        if (beat_go && pix_in.last) begin
          nxt_st.gen = GEN_COLLECT;
        end
      end
      GEN_COLLECT: begin
        // First line loads, later lines add; overlong pixels dropped
        if (beat_go && (st_ff.idx < IDX_W'(NUM_PIX))) begin
          if (st_ff.line_cnt == '0) begin
            nxt_st.acc[st_ff.idx[IDX_W-2:0]] = {
              {DOSG_LINES_LOG2{1'b0}}, pix_in.data};
          end else begin
            nxt_st.acc[st_ff.idx[IDX_W-2:0]] =
              st_ff.acc[st_ff.idx[IDX_W-2:0]] +
              {{DOSG_LINES_LOG2{1'b0}}, pix_in.data};
          end
        end
        // Count whole lines; the 64th ends the collection
        if (beat_go && pix_in.last) begin
          nxt_st.line_cnt = st_ff.line_cnt + 1'b1;
          if (st_ff.line_cnt == DOSG_LINES_LOG2'(DOSG_DARK_LINES - 1)) begin
            nxt_st.gen = GEN_FIND;
            nxt_st.scan = '0;
            nxt_st.ref_lvl = '0;
          end
        end
      end
      GEN_FIND: begin
        // One pixel per cycle; ties keep the earlier pixel
        if (scan_avg > st_ff.ref_lvl) begin
          nxt_st.ref_lvl = scan_avg;
        end
        if (st_ff.scan == IDX_W'(NUM_PIX - 1)) begin
          nxt_st.gen = GEN_STORE;
          nxt_st.scan = '0;
        end else begin
          nxt_st.scan = st_ff.scan + 1'b1;
        end
      end
      GEN_STORE: begin
        // Table write happens through tbl_wr, one pixel per cycle
        if (st_ff.scan == IDX_W'(NUM_PIX - 1)) begin
          nxt_st.gen = GEN_IDLE;
          nxt_st.scan = '0;
          nxt_st.user_act = 1'b1;
          nxt_st.set_valid[st_ff.gen_set] = 1'b1;
        end else begin
          nxt_st.scan = st_ff.scan + 1'b1;
        end
      end
      default: begin
        nxt_st.gen = GEN_IDLE;
      end
    endcase
  end

  // State register; accumulators need no reset value but get one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '0;
      st_ff.gen <= GEN_IDLE;
      st_ff.mode <= DOSG_RST_MODE;
      st_ff.single_line <= DOSG_RST_SINGLE;
      st_ff.user_act <= DOSG_RST_USER_ACT;
    end else begin
      st_ff <= nxt_st;
    end
  end
endmodule
`default_nettype wire

/* tb/dosg_props.sv */
// Port-level assertions for the shading generator top module
`timescale 1ns/1ps
`default_nettype none
module dosg_props #(
  parameter int NUM_PIX = 2048,
  parameter int FIFO_DEPTH = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire dosg_pkg::dosg_apb_req_t apb_req,
  input wire dosg_pkg::dosg_apb_rsp_t apb_rsp,
  input wire logic pix_in_valid,
  input wire logic pix_in_ready,
  input wire dosg_pkg::dosg_pix_t pix_in,
  input wire logic px_out_valid,
  input wire logic px_out_ready,
  input wire dosg_pkg::dosg_pix_t px_out,
  input wire logic line_valid
);
  import dosg_pkg::*;
  // Shadow of host-visible state, rebuilt from port traffic
  typedef struct packed {
    logic run; // Generation in progress
    logic [7:0] lines; // Lines closed since the start
    logic [4:0] occ; // Beats held in the buffer
    logic [2:0] mode; // Single bit and selection
    logic set_at; // Set chosen when the run began
    logic act; // User table in use
    logic [1:0] vset; // Sets written by a run
  } dosg_shadow_t;
  dosg_shadow_t st_ff, nxt_st;
  logic wr_acc, rd_acc, in_hs, out_hs, gen_go;
  assign wr_acc = apb_req.psel && apb_req.penable && apb_rsp.pready
    && apb_req.pwrite;
  assign rd_acc = apb_req.psel && apb_req.penable && apb_rsp.pready
    && !apb_req.pwrite;
  assign in_hs = pix_in_valid && pix_in_ready;
  assign out_hs = px_out_valid && px_out_ready;
  assign gen_go = wr_acc && apb_req.paddr == DOSG_ADDR_GEN
    && apb_req.pwdata[0];
  // Next shadow state from finished transfers and stream handshakes
  always_comb begin
    nxt_st = st_ff;
    nxt_st.occ = st_ff.occ + 5'(in_hs) - 5'(out_hs);
    if (st_ff.run && in_hs && pix_in.last) begin
      nxt_st.lines = st_ff.lines + 8'h01;
    end
    // Pready back high means the run stored and activated its set
    if (st_ff.run && apb_rsp.pready) begin
      nxt_st.run = 1'b0;
      nxt_st.act = 1'b1;
      nxt_st.vset[st_ff.set_at] = 1'b1;
    end
    if (wr_acc && apb_req.paddr == DOSG_ADDR_MODE) begin
      nxt_st.mode = {apb_req.pwdata[4], apb_req.pwdata[1:0]};
    end
    if (wr_acc && apb_req.paddr == DOSG_ADDR_ACTIVE) begin
      nxt_st.act = apb_req.pwdata[0];
    end
    if (gen_go) begin
      nxt_st.run = 1'b1;
      nxt_st.lines = 8'h00;
      nxt_st.set_at = st_ff.mode[2];
    end
  end
  // Shadow register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence s_start;
    gen_go;
  endsequence
  sequence s_stall;
    !apb_rsp.pready [*8];
  endsequence
  a_gen_stall: assert property (s_start |=> s_stall)
    else $error("command answered right after generation start");
  a_gen_lines: assert property (st_ff.run && apb_rsp.pready |->
    st_ff.lines >= 8'd64) else $error("generation ended too early");
  a_fifo_full: assert property (!pix_in_ready |->
    st_ff.occ == 5'(FIFO_DEPTH)) else $error("input refused while not full");
  a_out_valid: assert property (1'b1 |->
    px_out_valid == (st_ff.occ != 5'd0)) else $error("output valid wrong");
  a_in_to_out: assert property (in_hs |=> px_out_valid)
    else $error("accepted beat not offered");
  a_line_span: assert property (px_out_valid |-> line_valid)
    else $error("line valid low while data valid");
  a_line_hold: assert property (out_hs && !px_out.last |=>
    line_valid) else $error("line valid dropped inside a line");
  a_line_end: assert property (out_hs && px_out.last |=>
    line_valid == px_out_valid) else $error("line valid stuck high");
  a_mode_read: assert property (rd_acc &&
    apb_req.paddr == DOSG_ADDR_MODE |->
    {apb_rsp.prdata[4], apb_rsp.prdata[1:0]} == st_ff.mode)
    else $error("mode readback wrong");
  a_active_read: assert property (rd_acc &&
    apb_req.paddr == DOSG_ADDR_ACTIVE |-> apb_rsp.prdata[0] == st_ff.act)
    else $error("active table readback wrong");
  a_set_valid: assert property (rd_acc &&
    apb_req.paddr == DOSG_ADDR_STATUS |->
    apb_rsp.prdata[3:1] == {st_ff.vset[0], st_ff.vset[1], st_ff.act})
    else $error("status table flags wrong");
endmodule
bind dosg_top dosg_props #(
  .NUM_PIX(NUM_PIX),
  .FIFO_DEPTH(FIFO_DEPTH)
) i_props (
  .pclk(pclk),
  .presetn(presetn),
  .apb_req(apb_req),
  .apb_rsp(apb_rsp),
  .pix_in_valid(pix_in_valid),
  .pix_in_ready(pix_in_ready),
  .pix_in(pix_in),
  .px_out_valid(px_out_valid),
  .px_out_ready(px_out_ready),
  .px_out(px_out),
  .line_valid(line_valid)
);
`default_nettype wire

/* tb/dosg_sink.sv */
// Frame grabber model that sinks the corrected pixel stream
`timescale 1ns/1ps
`default_nettype none
module dosg_sink (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic stall,
  input wire logic slow,
  input wire logic px_out_valid,
  input wire dosg_pkg::dosg_pix_t px_out,
  output logic px_out_ready
);
  import dosg_pkg::*;
  logic [DOSG_PIX_W-1:0] got[$]; // Pixel values in arrival order
  // Ready lags stall by a cycle; slow halves the take rate
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      px_out_ready <= 1'b0;
    end else begin
      px_out_ready <= !stall && !(slow && px_out_ready);
      if (px_out_valid && px_out_ready) begin
        got.push_back(px_out.data);
      end
    end
  end
endmodule
`default_nettype wire

/* tb/dosg_top_tb.sv */
// Self-checking bench of the shading generator top module
`timescale 1ns/1ps
`default_nettype none
module dosg_top_tb;
  import dosg_pkg::*;
  localparam int NPIX = 32; // Short lines keep the run brief
  localparam int LIM = 20000; // Bound on every wait
  logic pclk, presetn, pix_in_valid, pix_in_ready, px_out_valid;
  logic px_out_ready, line_valid, stall, slow, err;
  dosg_apb_req_t apb_req;
  dosg_apb_rsp_t apb_rsp;
  dosg_pix_t pix_in, px_out;
  logic [31:0] rd;
  int err_total, num_checks;
  dosg_top #(.NUM_PIX(NPIX), .FIFO_DEPTH(16)) i_dut (.pclk(pclk),
    .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp),
    .pix_in_valid(pix_in_valid), .pix_in_ready(pix_in_ready),
    .pix_in(pix_in), .px_out_valid(px_out_valid),
    .px_out_ready(px_out_ready), .px_out(px_out), .line_valid(line_valid));
  dosg_sink i_sink (.pclk(pclk), .presetn(presetn), .stall(stall),
    .slow(slow), .px_out_valid(px_out_valid), .px_out(px_out),
    .px_out_ready(px_out_ready));
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    num_checks++;
    if (seen !== want) begin
      err_total++;
      $display("wrong value at %0t: got %h want %h", $time, seen, want);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // One APB transfer; waits for pready with a bound
  task automatic apb(input logic wr, input logic [11:0] a,
    input logic [31:0] d);
    int i;
    apb_req <= {1'b1, 1'b0, wr, a, d};
    @(posedge pclk);
    apb_req.penable <= 1'b1;
    // Answer and data are taken at the edge that sees pready high
    for (i = 0; i < LIM; i++) begin
      @(posedge pclk);
      if (apb_rsp.pready === 1'b1) break;
    end
    rd = apb_rsp.prdata;
    err = apb_rsp.pslverr;
    if (i == LIM) begin
      err_total++;
      results();
    end
    apb_req <= '0;
    @(posedge pclk);
  endtask
  // One pixel beat held until taken
  task automatic put(input logic last, input logic [11:0] d);
    int i;
    pix_in_valid <= 1'b1;
    pix_in <= {last, d};
    for (i = 0; i < LIM; i++) begin
      @(posedge pclk);
      if (pix_in_ready === 1'b1) break;
    end
    if (i == LIM) begin
      err_total++;
      results();
    end
  endtask
  // Dark pattern, brightest pixel 28 at index 23
  function automatic logic [11:0] v(input int i);
    return 12'((i * 5) % 29);
  endfunction
  task automatic line(input logic [11:0] add);
    for (int i = 0; i < NPIX; i++) put(i == NPIX - 1, v(i) + add);
    pix_in_valid <= 1'b0;
    @(posedge pclk);
  endtask
  // Wait for cnt beats at the sink, bounded
  task automatic drain(input int cnt);
    int i;
    for (i = 0; i < LIM && i_sink.got.size() < cnt; i++) @(posedge pclk);
    if (i == LIM) begin
      err_total++;
      results();
    end
  endtask
  // Flat lines expect the reference level everywhere
  task automatic expect_line(input logic flat);
    drain(NPIX);
    for (int i = 0; i < NPIX; i++) begin
      check(32'(i_sink.got[i]), flat ? 32'h1C : 32'(v(i)));
    end
    i_sink.got.delete();
  endtask
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  // Hang guard
  initial begin
    repeat (100000) @(posedge pclk);
    err_total++;
    results();
  end
  initial begin
    presetn = 1'b0;
    apb_req = '0;
    pix_in_valid = 1'b0;
    pix_in = '0;
    stall = 1'b0;
    slow = 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, DOSG_ADDR_STATUS, '0);
    check(rd, 32'h0);
    apb(1'b0, 12'h020, '0);
    check(32'(err), 32'h1);
    // Every selection passes data with factory offsets of zero
    for (int m = 0; m < 4; m++) begin
      apb(1'b1, DOSG_ADDR_MODE, 32'(m));
      apb(1'b0, DOSG_ADDR_MODE, '0);
      check(rd, 32'(m));
      line(12'h000);
      expect_line(1'b0);
    end
    // Stall the grabber until the buffer refuses, then drain
    stall <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 16; i++) put(1'b0, v(i));
    @(posedge pclk);
    check(32'(pix_in_ready), 32'h0);
    stall <= 1'b0;
    for (int i = 16; i < NPIX; i++) put(i == NPIX - 1, v(i));
    pix_in_valid <= 1'b0;
    @(posedge pclk);
    expect_line(1'b0);
    // Dark run with noise; a status read stalls until it ends
    apb(1'b1, DOSG_ADDR_MODE, 32'h1);
    apb(1'b1, DOSG_ADDR_GEN, 32'h1);
    slow <= 1'b1;
    fork
      for (int l = 0; l < 64; l++) line(12'(l % 2));
      apb(1'b0, DOSG_ADDR_STATUS, '0);
    join
    slow <= 1'b0;
    drain(64 * NPIX);
    check(32'(i_sink.got.size()), 32'(64 * NPIX));
    i_sink.got.delete();
    apb(1'b0, DOSG_ADDR_STATUS, '0);
    check(rd & 32'hF, 32'hA);
    apb(1'b0, DOSG_ADDR_REF, '0);
    check(rd, 32'h1C);
    line(12'h000);
    expect_line(1'b1);
    // Gain only ignores the offsets, both applies them
    apb(1'b1, DOSG_ADDR_MODE, 32'h2);
    line(12'h000);
    expect_line(1'b0);
    apb(1'b1, DOSG_ADDR_MODE, 32'h3);
    line(12'h000);
    expect_line(1'b1);
    // Single-line set was never generated, factory set is zero
    apb(1'b1, DOSG_ADDR_MODE, 32'h11);
    line(12'h000);
    expect_line(1'b0);
    apb(1'b1, DOSG_ADDR_MODE, 32'h1);
    apb(1'b1, DOSG_ADDR_ACTIVE, 32'h0);
    line(12'h000);
    expect_line(1'b0);
    results();
  end
endmodule
`default_nettype wire
